// ==== verilog/tss_pkg.sv ====
// Package for the thermal shutdown supervisor: register map, fields, timing.
// Assumes a 40 MHz system clock and a classic Wishbone register bus.
package tss_pkg;

  // Clock and timing
  localparam int unsigned CLK_HZ        = 40000000;
  localparam int unsigned LINK_TMO_MS   = 2000;
  localparam longint unsigned LINK_TMO_CYC_L = (longint'(CLK_HZ) * LINK_TMO_MS) / 1000;
  localparam int unsigned LINK_TMO_CYC  = int'(LINK_TMO_CYC_L);

  // Channel counts
  localparam int unsigned NUM_CELLS     = 12;
  localparam logic [3:0]  CELLS_TEN     = 4'hA;
  localparam logic [3:0]  CELLS_TWELVE  = 4'hC;

  // Register byte offsets
  localparam logic [7:0] REG_CFG        = 8'h00;
  localparam logic [7:0] REG_DISCHARGE  = 8'h04;
  localparam logic [7:0] REG_CMD        = 8'h08;
  localparam logic [7:0] REG_STATUS     = 8'h0C;
  localparam logic [7:0] REG_TEMP       = 8'h10;
  localparam logic [7:0] REG_CELL_USED  = 8'h14;

  // Configuration fields
  localparam int unsigned CFG_TEN_CELL  = 0;
  localparam int unsigned CFG_CONV_EN   = 1;
  localparam int unsigned CFG_GPIO_LO   = 2;
  localparam int unsigned GPIO_W        = 2;
  localparam logic [31:0] CFG_RESET     = 32'h0000_000C;
  localparam logic [11:0] DCH_RESET     = 12'h000;

  // Command fields: bit 0 start stack, bit 1 start single, bits 7:4 cell index
  localparam int unsigned CMD_STACK     = 0;
  localparam int unsigned CMD_SINGLE    = 1;
  localparam int unsigned CMD_IDX_LO    = 4;

  // Temperature group fields
  localparam int unsigned TEMP_FLAG_BIT = 31;

  // Status fields
  localparam int unsigned ST_STANDBY    = 0;
  localparam int unsigned ST_BUSY       = 1;
  localparam int unsigned ST_SUPERVISE  = 2;

  // Conversion request carrier
  typedef struct packed {
    logic       start;
    logic       single;
    logic [3:0] index;
    logic [3:0] count;
  } tss_conv_s;

  typedef enum logic [1:0] {
    TSS_ACTIVE,
    TSS_STANDBY
  } tss_mode_e;

endpackage

// ==== verilog/tss_link_watchdog.sv ====
// Link watchdog: counts idle cycles on the host link and flags a timeout.
// Assumes link activity arrives as a synchronous one-cycle or level strobe.
module tss_link_watchdog
  import tss_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = LINK_TMO_CYC
)
(
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic reset,
  // Activity in, timeout out
  input  wire logic activity,
  output logic      expired
);

  logic [31:0] count_ff;
  logic [31:0] nxt_count;
  wire         at_limit = (count_ff >= TIMEOUT_CYC - 32'd1);

  // Count up while idle, restart on any activity
  assign nxt_count = activity ? 32'h0000_0000
                   : (at_limit ? count_ff : count_ff + 32'h0000_0001);
  assign expired   = at_limit && !activity;

  // Idle counter
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      count_ff <= 32'h0000_0000;
    else
      count_ff <= nxt_count;
  end

endmodule

// ==== verilog/tss_supervisor.sv ====
// Thermal shutdown supervisor with conversion select, discharge and standby control.
// Assumes synchronous inputs and a classic Wishbone master on the register bus.
//
// Implementation choices: the register offsets and the Wishbone register port.
module tss_supervisor
  import tss_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = LINK_TMO_CYC
)
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Host link and temperature sensing
  input  wire logic        link_activity,
  input  wire logic        current_mode_active,
  input  wire logic        overtemp_detect,
  input  wire logic [11:0] die_temp_code,
  // Converter side
  input  wire logic        conv_done,
  output tss_conv_s        conv_req,
  output logic [3:0]       conv_cell_first,
  // Pins
  output logic [11:0]      discharge_gate_output,
  output logic [GPIO_W-1:0] gpio_out,
  output logic             watchdog_timeout_out,
  output logic             shutdown_active
);

  // Register state
  logic [31:0] cfg_ff;
  logic [11:0] dch_ff;
  logic [11:0] used_ff;
  logic        overtemp_shutdown_flag_ff;
  logic        busy_ff;
  logic        ack_ff;
  logic [31:0] rdata_ff;
  tss_mode_e   mode_ff;
  tss_conv_s   conv_ff;

  // Bus decode
  wire req        = wb_cyc_i && wb_stb_i && !ack_ff;
  wire wr         = req && wb_we_i;
  wire rd         = req && !wb_we_i;
  wire hit_cfg    = (wb_adr_i == REG_CFG);
  wire hit_dch    = (wb_adr_i == REG_DISCHARGE);
  wire hit_cmd    = (wb_adr_i == REG_CMD);
  wire hit_status = (wb_adr_i == REG_STATUS);
  wire hit_temp   = (wb_adr_i == REG_TEMP);
  wire hit_used   = (wb_adr_i == REG_CELL_USED);

  // Byte-lane merge for writes
  wire [31:0] lane_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                           {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire [31:0] cfg_merge = (cfg_ff & ~lane_mask) | (wb_dat_i & lane_mask);
  wire [31:0] dch_merge = ({20'h00000, dch_ff} & ~lane_mask) | (wb_dat_i & lane_mask);
  wire [31:0] use_merge = ({20'h00000, used_ff} & ~lane_mask) | (wb_dat_i & lane_mask);

  // Mode and supervision
  wire in_standby   = (mode_ff == TSS_STANDBY);
  wire supervise    = !in_standby || current_mode_active;
  wire thermal_trip = supervise && overtemp_detect;
  wire link_expired;

  // Link watchdog
  tss_link_watchdog #(
    .TIMEOUT_CYC (TIMEOUT_CYC)
  ) u_watchdog (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .activity (link_activity),
    .expired  (link_expired)
  );

  // Conversion command decode
  wire        cmd_wr     = wr && hit_cmd && wb_sel_i[0];
  wire        conv_en    = cfg_ff[CFG_CONV_EN];
  wire [3:0]  cmd_index  = wb_dat_i[CMD_IDX_LO +: 4];
  wire        idx_ok     = (cmd_index < 4'(NUM_CELLS));
  wire        start_stk  = cmd_wr && wb_dat_i[CMD_STACK] && conv_en && !busy_ff;
  wire        start_one  = cmd_wr && !wb_dat_i[CMD_STACK] && wb_dat_i[CMD_SINGLE]
                           && idx_ok && conv_en && !busy_ff;
  wire [3:0]  stk_count  = cfg_ff[CFG_TEN_CELL] ? CELLS_TEN : CELLS_TWELVE;

  // Temperature group readback, flag as it stood before the read
  wire        temp_rd    = rd && hit_temp;
  wire [31:0] temp_word  = {overtemp_shutdown_flag_ff, 19'h00000, die_temp_code};
  wire [31:0] status_word = {29'h00000000, supervise, busy_ff, in_standby};

  // Read data select; unmapped addresses read zero
  wire [31:0] rd_mux = hit_cfg    ? cfg_ff
                     : hit_dch    ? {20'h00000, dch_ff}
                     : hit_cmd    ? {24'h000000, conv_ff.index, 2'b00, conv_ff.single, busy_ff}
                     : hit_status ? status_word
                     : hit_temp   ? temp_word
                     : hit_used   ? {20'h00000, used_ff}
                     : 32'h0000_0000;

  // Bus handshake: one wait cycle, ack from flop
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      ack_ff   <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end
    else
    begin
      ack_ff   <= req;
      rdata_ff <= rd ? rd_mux : rdata_ff;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdata_ff;

  // Mode: standby after link silence, active again on activity
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      mode_ff <= TSS_ACTIVE;
    else if (link_activity)
      mode_ff <= TSS_ACTIVE;
    else if (link_expired)
      mode_ff <= TSS_STANDBY;
  end

  // Configuration: trip restores both defaults, standby restores the discharge default only
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      cfg_ff <= CFG_RESET;
      dch_ff <= DCH_RESET;
    end
    else if (thermal_trip)
    begin
      cfg_ff <= CFG_RESET;
      dch_ff <= DCH_RESET;
    end
    else if (in_standby)
      dch_ff <= DCH_RESET;
    else if (wr && hit_cfg)
      cfg_ff <= cfg_merge;
    else if (wr && hit_dch)
      dch_ff <= dch_merge[11:0];
  end

  // Cells in use; a clear bit marks an input tied to the top input
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      used_ff <= 12'hFFF;
    else if (wr && hit_used)
      used_ff <= use_merge[11:0];
  end

  // Sticky overtemperature flag; a new trip wins over the clearing read
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      overtemp_shutdown_flag_ff <= 1'b0;
    else if (thermal_trip)
      overtemp_shutdown_flag_ff <= 1'b1;
    else if (temp_rd)
      overtemp_shutdown_flag_ff <= 1'b0;
  end

  // Conversion request register; trip aborts the conversion
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      busy_ff <= 1'b0;
      conv_ff <= '0;
    end
    else if (thermal_trip || in_standby)
    begin
      busy_ff <= 1'b0;
      conv_ff <= '0;
    end
    else if (start_stk)
    begin
      busy_ff <= 1'b1;
      conv_ff <= '{start: 1'b1, single: 1'b0, index: 4'h0, count: stk_count};
    end
    else if (start_one)
    begin
      busy_ff <= 1'b1;
      conv_ff <= '{start: 1'b1, single: 1'b1, index: cmd_index, count: 4'h1};
    end
    else
    begin
      conv_ff.start <= 1'b0;
      busy_ff       <= busy_ff && !conv_done;
    end
  end

  assign conv_req        = conv_ff;
  // First channel whose input is tied to the top; results from it up read zero
  assign conv_cell_first = first_unused(used_ff);

  function automatic logic [3:0] first_unused(input logic [11:0] used);
    logic [3:0] idx;
    idx = CELLS_TWELVE;
    for (int i = NUM_CELLS - 1; i >= 0; i--)
      if (!used[i])
        idx = 4'(i);
    return idx;
  endfunction

  // Pins: discharge low means on; idle is pulled high
  assign discharge_gate_output = ~(dch_ff & {12{!in_standby}});
  assign shutdown_active       = in_standby;
  assign gpio_out              = shutdown_active ? {GPIO_W{1'b1}}
                                 : cfg_ff[CFG_GPIO_LO +: GPIO_W];
  assign watchdog_timeout_out  = !in_standby;

endmodule

// ==== bench/tss_supervisor_checker.sv ====
// Checker for the supervisor: bus answer, trip, standby and pin relations.
// Assumes it is bound to tss_supervisor and sees only its ports.
module tss_supervisor_checker
  import tss_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = LINK_TMO_CYC
)
(
  // Clock, reset and inputs
  input wire logic              clk_sys,
  input wire logic              reset,
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              link_activity,
  input wire logic              current_mode_active,
  input wire logic              overtemp_detect,
  // Outputs watched
  input wire logic              wb_ack_o,
  input wire tss_conv_s         conv_req,
  input wire logic [11:0]       discharge_gate_output,
  input wire logic [GPIO_W-1:0] gpio_out,
  input wire logic              watchdog_timeout_out,
  input wire logic              shutdown_active
);
  timeunit 1ns;
  timeprecision 100ps;
  int unsigned idle_cnt;

  // Idle cycles since the last link activity, saturating
  always_ff @(posedge clk_sys or posedge reset)
    if (reset)
      idle_cnt <= 0;
    else if (link_activity)
      idle_cnt <= 0;
    else if (idle_cnt < TIMEOUT_CYC + 4)
      idle_cnt <= idle_cnt + 1;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);

  chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_trip_off: assert property (
    (!shutdown_active || current_mode_active) && overtemp_detect
      |=> discharge_gate_output == 12'hFFF)
    else $error("discharge left on after trip");
  chk_trip_noconv: assert property (
    (!shutdown_active || current_mode_active) && overtemp_detect |=> !conv_req.start)
    else $error("conversion started after trip");
  chk_stby_off: assert property (shutdown_active |-> &discharge_gate_output)
    else $error("discharge on in standby");
  chk_wdt_low: assert property (watchdog_timeout_out == !shutdown_active)
    else $error("watchdog output disagrees with standby");
  chk_gpio_high: assert property (shutdown_active |-> &gpio_out)
    else $error("gpio not high in standby");
  chk_link_tmo: assert property (idle_cnt >= TIMEOUT_CYC + 2 |-> shutdown_active)
    else $error("standby not entered after link silence");
  chk_link_wake: assert property ($rose(link_activity) |-> ##[1:3] !shutdown_active)
    else $error("link activity did not wake");
  chk_single_idx: assert property (
    conv_req.start && conv_req.single |-> conv_req.index < 4'hC)
    else $error("single conversion index out of range");
endmodule

bind tss_supervisor tss_supervisor_checker #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_chk (
  .clk_sys(clk_sys), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .link_activity(link_activity), .current_mode_active(current_mode_active),
  .overtemp_detect(overtemp_detect),
  .wb_ack_o(wb_ack_o), .conv_req(conv_req), .discharge_gate_output(discharge_gate_output),
  .gpio_out(gpio_out), .watchdog_timeout_out(watchdog_timeout_out),
  .shutdown_active(shutdown_active));

// ==== bench/tss_host_model.sv ====
// Host link model: one activity pulse every eighth cycle while talking.
// Assumes the supervisor's clock and reset.
module tss_host_model
(
  // Clock, reset and control
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic talk,
  // Activity toward the device
  output logic     link_activity
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] cnt_ff;

  // Frame spacing counter
  always_ff @(posedge clk_sys or posedge reset)
    if (reset)
      cnt_ff <= 3'h0;
    else
      cnt_ff <= cnt_ff + 3'h1;

  // Silent link when not talking
  assign link_activity = talk && (cnt_ff == 3'h0);
endmodule

// ==== bench/tss_supervisor_bench.sv ====
// Bench for the supervisor: Wishbone tasks, conversions, trip and standby.
// Assumes a shortened link timeout and a host model for link activity.
module tss_supervisor_bench
  import tss_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned TMO = 50;
  logic clk_sys = 1'b0, reset = 1'b1, talk = 1'b1, conv_done = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o, link_activity;
  logic current_mode_active = 1'b0, overtemp_detect = 1'b0, watchdog_timeout_out;
  logic shutdown_active;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic [11:0] discharge_gate_output, die_temp_code = 12'h123;
  logic [3:0] conv_cell_first;
  logic [1:0] gpio_out;
  tss_conv_s conv_req, got;
  int num_errors = 0, samples_checked = 0, starts = 0, n;

  always #12.5 clk_sys = ~clk_sys;

  tss_supervisor #(.TIMEOUT_CYC(TMO)) dut (.clk_sys(clk_sys), .reset(reset),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .link_activity(link_activity), .current_mode_active(current_mode_active),
    .overtemp_detect(overtemp_detect), .die_temp_code(die_temp_code),
    .conv_done(conv_done), .conv_req(conv_req), .conv_cell_first(conv_cell_first),
    .discharge_gate_output(discharge_gate_output), .gpio_out(gpio_out),
    .watchdog_timeout_out(watchdog_timeout_out), .shutdown_active(shutdown_active));
  tss_host_model u_host (.clk_sys(clk_sys), .reset(reset), .talk(talk),
    .link_activity(link_activity));

  // Capture each conversion request
  always @(posedge clk_sys)
    if (conv_req.start === 1'b1)
    begin
      got <= conv_req;
      starts <= starts + 1;
    end

  task automatic conclude;
    $display("Checked %0d, errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    if (n >= 20)
    begin
      num_errors++;
      conclude();
    end
  endtask

  // Command write, wait for the request, then finish it
  task automatic conv(input logic [31:0] cmd, input int inc);
    int k;
    k = starts;
    wb(1'b1, REG_CMD, cmd);
    for (int i = 0; i < 10 && starts == k; i++)
      @(posedge clk_sys);
    chk(starts, k + inc);
    conv_done <= 1'b1;
    @(posedge clk_sys);
    conv_done <= 1'b0;
  endtask

  task automatic trip;
    overtemp_detect <= 1'b1;
    @(posedge clk_sys);
    overtemp_detect <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask

  // Main sequence
  initial
  begin
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    chk(discharge_gate_output, 12'hFFF);
    wb(1'b0, REG_CFG, 32'h0);
    chk(rd, CFG_RESET);
    wb(1'b1, REG_CFG, 32'h3);
    conv(32'h1, 1);
    chk(got.count, CELLS_TEN);
    chk(gpio_out, 2'h0);
    wb(1'b1, REG_CFG, 32'h2);
    conv(32'h1, 1);
    chk(got.count, CELLS_TWELVE);
    conv(32'h52, 1);
    chk({got.single, got.index}, 5'h15);
    conv(32'hC2, 0);
    wb(1'b1, REG_CELL_USED, 32'h07F);
    wb(1'b0, REG_CELL_USED, 32'h0);
    chk(conv_cell_first, 4'h7);
    wb(1'b1, REG_DISCHARGE, 32'h5);
    wb(1'b0, REG_DISCHARGE, 32'h0);
    chk(discharge_gate_output, 12'hFFA);
    trip();
    chk(discharge_gate_output, 12'hFFF);
    wb(1'b0, REG_CFG, 32'h0);
    chk(rd, CFG_RESET);
    conv(32'h1, 0);
    wb(1'b0, REG_TEMP, 32'h0);
    chk(rd, 32'h8000_0123);
    wb(1'b0, REG_TEMP, 32'h0);
    chk(rd, 32'h0000_0123);
    wb(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h0);
    wb(1'b1, REG_CFG, 32'h0);
    chk(gpio_out, 2'h0);
    talk <= 1'b0;
    for (int i = 0; i < TMO + 20 && shutdown_active !== 1'b1; i++)
      @(posedge clk_sys);
    chk(shutdown_active, 1'b1);
    chk(watchdog_timeout_out, 1'b0);
    chk(gpio_out, 2'h3);
    wb(1'b1, REG_DISCHARGE, 32'hFFF);
    wb(1'b0, REG_STATUS, 32'h0);
    chk(rd, 32'h0000_0001);
    chk(discharge_gate_output, 12'hFFF);
    trip();
    wb(1'b0, REG_TEMP, 32'h0);
    chk(rd[31], 1'b0);
    current_mode_active <= 1'b1;
    trip();
    wb(1'b0, REG_TEMP, 32'h0);
    chk(rd[31], 1'b1);
    talk <= 1'b1;
    repeat (12) @(posedge clk_sys);
    chk(watchdog_timeout_out, 1'b1);
    // Mid-run reset restores defaults
    wb(1'b1, REG_CFG, 32'h3);
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    wb(1'b0, REG_CFG, 32'h0);
    chk(rd, CFG_RESET);
    chk(shutdown_active, 1'b0);
    conclude();
  end
endmodule
